// [common/timer16_pkg.sv]
// constants and types shared by the 16-bit capture/compare timer
`default_nettype none
package timer16_pkg;

    // ---------------------------------------------------------------
    // register byte offsets on the AXI4-Lite slave
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PRM    = 8'h04;
    localparam logic [7:0] OFF_PRMBIT = 8'h08;
    localparam logic [7:0] OFF_CNT    = 8'h0c;
    localparam logic [7:0] OFF_CC1    = 8'h10;
    localparam logic [7:0] OFF_CC2    = 8'h14;
    localparam logic [7:0] OFF_STAT   = 8'h18;
    localparam logic [7:0] OFF_MASK   = 8'h1c;

    // ---------------------------------------------------------------
    // control register fields and reset values
    // ---------------------------------------------------------------
    localparam int CTRL_OP_LO   = 0;
    localparam int CTRL_CC1_CAP = 2;
    localparam int CTRL_CC1_TRG = 3;
    localparam int CTRL_CC2_CAP = 4;
    localparam logic [1:0] OP_STOP   = 2'h0;
    localparam logic [7:0] PRM_RESET = 8'h00;
    localparam logic [2:0] STAT_RESET = 3'h0;

    // status and mask bit positions
    localparam int ST_CC1  = 0;
    localparam int ST_CC2  = 1;
    localparam int ST_WRAP = 2;

    // internal prescaler: divide by four
    localparam logic [1:0] DIV_LAST = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // count clock and edge selections
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_FULL    = 2'h0,
        CLK_DIV     = 2'h1,
        CLK_CASCADE = 2'h2,
        CLK_INPUT   = 2'h3
    } clk_sel_t;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_NONE = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_t;

    // layout of the prescale mode register
    typedef struct packed {
        edge_sel_t  edge_second;
        edge_sel_t  edge_first;
        logic [1:0] spare;
        clk_sel_t   clk_sel;
    } prescale_mode_t;

endpackage
`default_nettype wire

// [hw/timer16_capture_compare.sv]
// 16-bit free-running timer with two capture/compare channels
//
// Operation
// - prescale mode register picks count clock and both input edges
// - prescale mode accepts byte writes and single-bit writes only while stopped
// - reset clears prescale mode to zero
// - clock select 11 counts valid edges of the first input
// - first enable after reset sees a high input as rising edge
// - re-enable after a stop sees no edge from a high input
// - counter read returns the live count
// - first channel compare match raises the first match interrupt
// - compare matches never clear the counter
// - first channel captures the count on either selected input
// - second channel compare match raises the second interrupt
// - second channel capture trigger is the first input only
// - second channel capture loads the current count
// - partner 8-bit timer carry may clock the counter, 24 bits
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    input  wire logic        timer_input_first,
    input  wire logic        timer_input_second,
    input  wire logic        cascade_partner_tick,
    output var  logic        match_irq_first,
    output var  logic        match_irq_second,
    output var  logic        irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    timer16_pkg::prescale_mode_t prm_r;
    logic [1:0]  op_mode_r;
    logic        cc1_cap_r;
    logic        cc1_trg_r;
    logic        cc2_cap_r;
    logic [15:0] cnt_r;
    logic [15:0] cc1_r;
    logic [15:0] cc2_r;
    logic [2:0]  stat_r;
    logic [2:0]  stat_nxt;
    logic [2:0]  mask_r;
    logic [1:0]  div_r;
    logic        in1_prev_r;
    logic        in2_prev_r;
    logic        ran_once_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  waddr_r;
    logic [31:0] wdat_r;
    logic [3:0]  wstb_r;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic edge_hit(
        input timer16_pkg::edge_sel_t sel,
        input logic                   prev,
        input logic                   cur
    );
        case (sel)
            timer16_pkg::EDGE_FALL: return prev & ~cur;
            timer16_pkg::EDGE_RISE: return ~prev & cur;
            timer16_pkg::EDGE_BOTH: return prev ^ cur;
            default:                return 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] dat,
        input logic [3:0]  stb
    );
        return {stb[1] ? dat[15:8] : old[15:8],
                stb[0] ? dat[7:0]  : old[7:0]};
    endfunction

    // ---------------------------------------------------------------
    // edge detection and count clock
    // ---------------------------------------------------------------
    wire        running = op_mode_r != timer16_pkg::OP_STOP;
    wire        e1 = running &
                edge_hit(prm_r.edge_first, in1_prev_r,
                         timer_input_first);
    wire        e2 = running &
                edge_hit(prm_r.edge_second, in2_prev_r,
                         timer_input_second);
    // count clock source mux
    wire        tick = running & (
        (prm_r.clk_sel == timer16_pkg::CLK_FULL) |
        (prm_r.clk_sel == timer16_pkg::CLK_DIV &&
         div_r == timer16_pkg::DIV_LAST) |
        (prm_r.clk_sel == timer16_pkg::CLK_CASCADE &&
         cascade_partner_tick) |
        (prm_r.clk_sel == timer16_pkg::CLK_INPUT && e1));
    wire [15:0] cnt_inc = cnt_r + 16'h0001;

    // compare matches are taken on the count step into the value
    wire cmp1 = tick & ~cc1_cap_r & (cnt_inc == cc1_r);
    wire cmp2 = tick & ~cc2_cap_r & (cnt_inc == cc2_r);
    wire cap1 = cc1_cap_r & (cc1_trg_r ? e2 : e1);
    wire cap2 = cc2_cap_r & e1;
    wire wrap = tick & (cnt_r == 16'hffff);
    wire [2:0] events = {wrap, cmp2 | cap2, cmp1 | cap1};

    // ---------------------------------------------------------------
    // register write decode
    // ---------------------------------------------------------------
    wire do_write = aw_held_r & w_held_r & ~bvalid;
    wire hit_w = waddr_r == timer16_pkg::OFF_CTRL ||
                 waddr_r == timer16_pkg::OFF_PRM ||
                 waddr_r == timer16_pkg::OFF_PRMBIT ||
                 waddr_r == timer16_pkg::OFF_CNT ||
                 waddr_r == timer16_pkg::OFF_CC1 ||
                 waddr_r == timer16_pkg::OFF_CC2 ||
                 waddr_r == timer16_pkg::OFF_STAT ||
                 waddr_r == timer16_pkg::OFF_MASK;
    wire wr_ctrl = do_write & wstb_r[0] &
                   (waddr_r == timer16_pkg::OFF_CTRL);
    // prescale writes while running are dropped to keep counting sane
    wire wr_prm  = do_write & wstb_r[0] & ~running &
                   (waddr_r == timer16_pkg::OFF_PRM);
    wire wr_pbit = do_write & wstb_r[0] & ~running &
                   (waddr_r == timer16_pkg::OFF_PRMBIT);
    wire wr_cc1  = do_write & (waddr_r == timer16_pkg::OFF_CC1);
    wire wr_cc2  = do_write & (waddr_r == timer16_pkg::OFF_CC2);
    wire wr_stat = do_write & wstb_r[0] &
                   (waddr_r == timer16_pkg::OFF_STAT);
    wire wr_mask = do_write & wstb_r[0] &
                   (waddr_r == timer16_pkg::OFF_MASK);
    wire [7:0] prm_bit_mask = 8'h01 << wdat_r[2:0];
    // single-bit update: index in bits 2:0, value in bit 3
    wire [7:0] prm_bit_val = wdat_r[3] ? (prm_r | prm_bit_mask)
                                       : (prm_r & ~prm_bit_mask);

    // ---------------------------------------------------------------
    // register read decode
    // ---------------------------------------------------------------
    wire [31:0] rd_val =
        araddr == timer16_pkg::OFF_CTRL ?
            {27'h0, cc2_cap_r, cc1_trg_r, cc1_cap_r, op_mode_r} :
        araddr == timer16_pkg::OFF_PRM  ? {24'h0, prm_r} :
        araddr == timer16_pkg::OFF_CNT  ? {16'h0, cnt_r} :
        araddr == timer16_pkg::OFF_CC1  ? {16'h0, cc1_r} :
        araddr == timer16_pkg::OFF_CC2  ? {16'h0, cc2_r} :
        araddr == timer16_pkg::OFF_STAT ? {29'h0, stat_r} :
        araddr == timer16_pkg::OFF_MASK ? {29'h0, mask_r} : 32'h0;
    wire hit_r = araddr == timer16_pkg::OFF_CTRL ||
                 araddr == timer16_pkg::OFF_PRM ||
                 araddr == timer16_pkg::OFF_PRMBIT ||
                 araddr == timer16_pkg::OFF_CNT ||
                 araddr == timer16_pkg::OFF_CC1 ||
                 araddr == timer16_pkg::OFF_CC2 ||
                 araddr == timer16_pkg::OFF_STAT ||
                 araddr == timer16_pkg::OFF_MASK;

    // a new event beats a write-one-to-clear in the same cycle
    assign stat_nxt = (stat_r & ~({3{wr_stat}} & wdat_r[2:0])) | events;

    // ---------------------------------------------------------------
    // AXI4-Lite write channel: address and data taken in any order
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            waddr_r   <= 8'h00;
            wdat_r    <= 32'h0;
            wstb_r    <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= timer16_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready   <= 1'b0;
                aw_held_r <= 1'b1;
                waddr_r   <= awaddr;
            end
            if (wvalid && wready) begin
                wready   <= 1'b0;
                w_held_r <= 1'b1;
                wdat_r   <= wdata;
                wstb_r   <= wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= hit_w ? timer16_pkg::RESP_OKAY
                                   : timer16_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel: one read in flight, data registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= timer16_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_val;
            rresp   <= hit_r ? timer16_pkg::RESP_OKAY
                             : timer16_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prm_r     <= timer16_pkg::PRM_RESET;
            op_mode_r <= timer16_pkg::OP_STOP;
            cc1_cap_r <= 1'b0;
            cc1_trg_r <= 1'b0;
            cc2_cap_r <= 1'b0;
            mask_r    <= 3'h0;
        end else begin
            if (wr_prm)
                prm_r <= wdat_r[7:0];
            else if (wr_pbit)
                prm_r <= prm_bit_val;
            if (wr_ctrl) begin
                op_mode_r <= wdat_r[timer16_pkg::CTRL_OP_LO +: 2];
                cc1_cap_r <= wdat_r[timer16_pkg::CTRL_CC1_CAP];
                cc1_trg_r <= wdat_r[timer16_pkg::CTRL_CC1_TRG];
                cc2_cap_r <= wdat_r[timer16_pkg::CTRL_CC2_CAP];
            end
            if (wr_mask)
                mask_r <= wdat_r[2:0];
        end
    end

    // ---------------------------------------------------------------
    // input history: held low until the first enable after reset,
    // so a high input then counts as a rising edge; afterwards it
    // tracks the pin even while stopped, so re-enabling sees none
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in1_prev_r <= 1'b0;
            in2_prev_r <= 1'b0;
            ran_once_r <= 1'b0;
        end else begin
            ran_once_r <= ran_once_r | running;
            if (running || ran_once_r) begin
                in1_prev_r <= timer_input_first;
                in2_prev_r <= timer_input_second;
            end
        end
    end

    // counter and prescaler; a stop clears both
    always_ff @(posedge aclk) begin
        if (!aresetn || !running) begin
            cnt_r <= 16'h0;
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
            if (tick)
                cnt_r <= cnt_inc;
        end
    end

    // capture/compare channels; a capture beats a software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cc1_r <= 16'h0;
            cc2_r <= 16'h0;
        end else begin
            if (cap1)
                cc1_r <= cnt_r;
            else if (wr_cc1)
                cc1_r <= merge16(cc1_r, wdat_r, wstb_r);
            if (cap2)
                cc2_r <= cnt_r;
            else if (wr_cc2)
                cc2_r <= merge16(cc2_r, wdat_r, wstb_r);
        end
    end

    // sticky status, interrupt pulses and masked level interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r           <= timer16_pkg::STAT_RESET;
            match_irq_first  <= 1'b0;
            match_irq_second <= 1'b0;
            irq              <= 1'b0;
        end else begin
            stat_r           <= stat_nxt;
            match_irq_first  <= events[timer16_pkg::ST_CC1];
            match_irq_second <= events[timer16_pkg::ST_CC2];
            irq              <= |(stat_nxt & mask_r);
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_prm_reset;
        disable iff (1'b0) !aresetn |=> prm_r == timer16_pkg::PRM_RESET;
    endproperty
    a_prm_reset: assert property (p_prm_reset)
        else $error("prescale mode not cleared by reset");

    property p_hold;
        running && !tick |=> $stable(cnt_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved without a count clock");

    property p_wrap;
        running && tick && cnt_r == 16'hffff |=> cnt_r == 16'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to zero");

    property p_input_clock;
        prm_r.clk_sel == timer16_pkg::CLK_INPUT && running
        ##1 (running && !e1) [*2] |-> $stable(cnt_r);
    endproperty
    a_input_clock: assert property (p_input_clock)
        else $error("input clocking counted without an edge");

    property p_first_rise;
        !ran_once_r && !running ##1 running && timer_input_first &&
        prm_r.edge_first == timer16_pkg::EDGE_RISE |-> e1;
    endproperty
    a_first_rise: assert property (p_first_rise)
        else $error("high input not seen as rising at first enable");

    property p_no_rerise;
        ran_once_r && !running && timer_input_first
        ##1 running && timer_input_first |-> !e1;
    endproperty
    a_no_rerise: assert property (p_no_rerise)
        else $error("false rising edge after re-enable");

    property p_match1;
        cmp1 |=> match_irq_first && stat_r[timer16_pkg::ST_CC1] &&
                 cnt_r == cc1_r;
    endproperty
    a_match1: assert property (p_match1)
        else $error("first compare match not signalled");

    property p_match2;
        cmp2 |=> match_irq_second && cnt_r == $past(cnt_inc);
    endproperty
    a_match2: assert property (p_match2)
        else $error("second compare match not signalled");

    property p_cap1;
        cap1 |=> cc1_r == $past(cnt_r) ##1 stat_r[timer16_pkg::ST_CC1];
    endproperty
    a_cap1: assert property (p_cap1)
        else $error("first channel capture lost");

    property p_cap2;
        cc2_cap_r && e1 |=> cc2_r == $past(cnt_r);
    endproperty
    a_cap2: assert property (p_cap2)
        else $error("second channel capture lost");

    property p_cascade;
        running && prm_r.clk_sel == timer16_pkg::CLK_CASCADE &&
        !cascade_partner_tick |=> $stable(cnt_r);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade counter moved without partner carry");

    property p_cnt_read;
        arvalid && arready && araddr == timer16_pkg::OFF_CNT
        |=> rvalid && rdata[15:0] == $past(cnt_r);
    endproperty
    a_cnt_read: assert property (p_cnt_read)
        else $error("counter read returned a stale value");

    property p_bit_write;
        wr_pbit |=> prm_r == $past(prm_bit_val);
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("single-bit prescale write not applied");

    c_wrap:    cover property (wrap);
    c_match:   cover property (cmp1 ##[1:50] cmp2);
    c_capture: cover property (cap1 ##[1:50] cap2);
    c_irq:     cover property ($rose(irq));

endmodule
`default_nettype wire

// [tb/edge_source.sv]
// partner model: external edge sources driving the timer inputs
`timescale 1ns/1ps
`default_nettype none
module edge_source (
    input  wire logic aclk,
    output var  logic first_pin,
    output var  logic second_pin,
    output var  logic tick
);
    // first input rests high, as a pulled-up pin would
    initial begin
        first_pin = 1'b1;
        second_pin = 1'b0;
        tick = 1'b0;
    end

    // low then high, two cycles each, so each pulse is one rising edge
    task automatic pulse_first(input int n);
        repeat (n) begin
            @(posedge aclk);
            first_pin <= 1'b0;
            repeat (2) @(posedge aclk);
            first_pin <= 1'b1;
            repeat (2) @(posedge aclk);
        end
    endtask

    // the shared pin only ever carries input edges here
    task automatic pulse_second();
        @(posedge aclk);
        second_pin <= 1'b1;
        repeat (2) @(posedge aclk);
        second_pin <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // carry pulses of the cascade partner, one cycle wide with a gap
    task automatic pulse_tick(input int n);
        repeat (n) begin
            @(posedge aclk);
            tick <= 1'b1;
            @(posedge aclk);
            tick <= 1'b0;
            @(posedge aclk);
        end
    endtask
endmodule
`default_nettype wire

// [tb/timer16_capture_compare_tb.sv]
// self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic        m1, m2, irq, tin1, tin2, tick;
    int          mismatches = 0, compares = 0, cycles = 0, m1_seen = 0;
    int          m2_seen = 0;
    int          n, t, k;

    always #20 aclk = ~aclk;

    edge_source u_src (.aclk(aclk), .first_pin(tin1), .second_pin(tin2),
        .tick(tick));

    timer16_capture_compare u_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .timer_input_first(tin1),
        .timer_input_second(tin2), .cascade_partner_tick(tick),
        .match_irq_first(m1), .match_irq_second(m2), .irq(irq));

    // ----------------------------------------------------------------
    // bus tasks, comparison and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        // response kept for checking; bready simply stays high
        rs = bresp;
    endtask

    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
    endtask

    task automatic report_and_stop;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // model of match pulses, and the hang limit
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (m1 === 1'b1) m1_seen <= m1_seen + 1;
        if (m2 === 1'b1) m2_seen <= m2_seen + 1;
        if (cycles == 6000) begin
            mismatches++;
            report_and_stop;
        end
    end

    // ----------------------------------------------------------------
    // scenarios; prescale mode is only written while stopped
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(75841));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(timer16_pkg::OFF_PRM);
        chk(rd, 32'h0);
        axr(8'h40);
        chk({30'h0, rs}, {30'h0, timer16_pkg::RESP_SLVERR});
        axw(8'h44, 32'h0);
        chk({30'h0, rs}, {30'h0, timer16_pkg::RESP_SLVERR});
        // count first-input rising edges; no capture mode set
        axw(timer16_pkg::OFF_PRM, 32'h13);
        chk({30'h0, rs}, {30'h0, timer16_pkg::RESP_OKAY});
        axr(timer16_pkg::OFF_PRM);
        chk(rd, 32'h13);
        axw(timer16_pkg::OFF_CTRL, 32'h1);
        axr(timer16_pkg::OFF_CNT);
        chk(rd, 32'h1);
        axw(timer16_pkg::OFF_CTRL, 32'h0);
        axw(timer16_pkg::OFF_CTRL, 32'h1);
        axr(timer16_pkg::OFF_CNT);
        chk(rd, 32'h0);
        n = $urandom_range(8, 1);
        u_src.pulse_first(n);
        axr(timer16_pkg::OFF_CNT);
        chk(rd, n);
        // single-bit write clears bit 0: clock from cascade carry
        axw(timer16_pkg::OFF_CTRL, 32'h0);
        axw(timer16_pkg::OFF_PRMBIT, 32'h0);
        axr(timer16_pkg::OFF_PRM);
        chk(rd, 32'h12);
        t = $urandom_range(8, 2);
        k = $urandom_range(t - 1, 1);
        axw(timer16_pkg::OFF_CC1, k);
        axw(timer16_pkg::OFF_MASK, 32'h3);
        axw(timer16_pkg::OFF_CTRL, 32'h11);
        u_src.pulse_tick(t);
        axr(timer16_pkg::OFF_STAT);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h1);
        chk(m1_seen, 32'h1);
        axr(timer16_pkg::OFF_CNT);
        chk(rd, t);
        u_src.pulse_first(1);
        axr(timer16_pkg::OFF_CC2);
        chk(rd, t);
        chk(m2_seen, 32'h1);
        axw(timer16_pkg::OFF_MASK, 32'h0);
        axr(timer16_pkg::OFF_STAT);
        chk(rd, 32'h3);
        chk({31'h0, irq}, 32'h0);
        axw(timer16_pkg::OFF_STAT, 32'h3);
        axw(timer16_pkg::OFF_MASK, 32'h3);
        axr(timer16_pkg::OFF_STAT);
        chk({rd[30:0], irq}, 32'h0);
        // first channel captures on a falling edge of the second input
        // second channel compares against the same count meanwhile
        axw(timer16_pkg::OFF_CTRL, 32'h0);
        n = $urandom_range(8, 1);
        axw(timer16_pkg::OFF_CC2, n);
        axw(timer16_pkg::OFF_CTRL, 32'h0d);
        u_src.pulse_tick(n);
        u_src.pulse_second();
        axr(timer16_pkg::OFF_CC1);
        chk(rd, n);
        axr(timer16_pkg::OFF_STAT);
        chk(rd, 32'h3);
        chk(m2_seen, 32'h2);
        axr(timer16_pkg::OFF_CNT);
        chk(rd, n);
        report_and_stop;
    end
endmodule
`default_nettype wire
